// *** osc_ctrl.sv ***
// Notes on behaviour
// - The fast rc clock is divided by 1,2,4,8,16,32,64 or 256 for divider codes 0 to 7, reset 0.
// - Bit 23 enables the low-power auxiliary mode when one, disables it when zero, reset zero.
// - Read-only bit 22 is one only while the secondary oscillator runs stably.
// - Read-only bits 14:12 show the active source with the defined code set.
// - Requested source, secondary enable and switch enable load from configuration at reset.
// - Switch enable resets to the value of the two-speed start-up configuration bit.
// - Control writes are refused unless an unlock sequence precedes them.
// - Bits 31:27, 21:15 and 11 read zero and ignore writes.
`timescale 1ns/1ps
module osc_ctrl (
    // clock and reset
    input  wire logic                      clk_sys_i,
    input  wire logic                      rst_i,
    // apb slave
    input  wire logic [osc_pkg::OSC_AW-1:0] paddr_i,
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [31:0]               pwdata_i,
    output logic      [31:0]               prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    // configuration settings
    input  wire logic [2:0]                cfg_req_source_i,
    input  wire logic                      cfg_sosc_enable_i,
    input  wire logic                      two_speed_startup_cfg_i,
    // clock source status
    input  wire logic [7:0]                src_ready_i,
    input  wire logic                      secondary_osc_ready_i,
    input  wire logic                      usb_pll_lock_i,
    input  wire logic                      sys_pll_lock_i,
    input  wire logic                      clock_fail_i,
    // clock system control
    output logic [2:0]                     active_clock_source_o,
    output logic                           fast_rc_tick_o,
    output logic                           aux_lowpower_enable_o,
    output logic                           sleep_enable_o,
    output logic                           secondary_osc_enable_o,
    output logic                           switch_busy_o,
    // interrupt
    output logic                           irq_o
);
    import osc_pkg::*;

    logic [2:0]           fast_rc_divider_reg;
    logic                 aux_lowpower_enable_reg;
    osc_src_t             active_clock_source_reg;
    osc_src_t             active_clock_source_next;
    logic [2:0]           requested_clock_source_reg;
    logic                 clock_lock_reg;
    logic                 sleep_enable_reg;
    logic                 clock_fail_flag_reg;
    logic                 clock_fail_flag_next;
    logic                 secondary_osc_enable_reg;
    logic                 clock_switch_enable_reg;
    logic                 clock_switch_enable_next;
    logic                 cfg_load_reg;
    osc_sw_state_t        sw_state_reg;
    osc_sw_state_t        sw_state_next;
    osc_key_state_t       key_state_reg;
    osc_key_state_t       key_state_next;
    logic [OSC_IRQ_W-1:0] irq_stat_reg;
    logic [OSC_IRQ_W-1:0] irq_stat_next;
    logic [OSC_IRQ_W-1:0] irq_mask_reg;
    logic [OSC_IRQ_W-1:0] irq_evt_w;
    logic                 srdy_prev_reg;
    logic [31:0]          prdata_reg;
    logic [31:0]          prdata_next;
    logic [31:0]          ctrl_word_w;

    logic                 setup_w;
    logic                 access_w;
    logic                 wr_access_w;
    logic                 hit_ctrl_w;
    logic                 hit_key_w;
    logic                 hit_stat_w;
    logic                 hit_mask_w;
    logic                 mapped_w;
    logic                 unlocked_w;
    logic                 busy_w;
    logic                 ctrl_refused_w;
    logic                 ctrl_wr_w;
    logic                 key_wr_w;
    logic                 stat_wr_w;
    logic                 mask_wr_w;
    logic                 sosc_ready_w;
    logic [2:0]           wr_req_w;
    logic                 wr_swen_w;
    logic                 fail_evt_w;
    logic                 switch_evt_w;

    // apb decode
    assign setup_w     = psel_i & ~penable_i;
    assign access_w    = psel_i & penable_i;
    assign wr_access_w = access_w & pwrite_i;
    assign hit_ctrl_w  = (paddr_i == OSC_CTRL_ADDR);
    assign hit_key_w   = (paddr_i == OSC_KEY_ADDR);
    assign hit_stat_w  = (paddr_i == OSC_STAT_ADDR);
    assign hit_mask_w  = (paddr_i == OSC_MASK_ADDR);
    assign mapped_w    = hit_ctrl_w | hit_key_w | hit_stat_w | hit_mask_w;

    assign unlocked_w     = (key_state_reg == OSC_KEY_OPEN);
    assign busy_w         = (sw_state_reg != OSC_SW_IDLE) | cfg_load_reg;
    // writes while locked or while a switch runs leave every bit alone
    assign ctrl_refused_w = hit_ctrl_w & wr_access_w & (~unlocked_w | busy_w);
    assign ctrl_wr_w      = hit_ctrl_w & wr_access_w & unlocked_w & ~busy_w;
    assign key_wr_w       = hit_key_w & wr_access_w;
    assign stat_wr_w      = hit_stat_w & wr_access_w;
    assign mask_wr_w      = hit_mask_w & wr_access_w;

    assign pready_o  = 1'b1;
    assign pslverr_o = access_w & (~mapped_w | ctrl_refused_w);
    assign prdata_o  = prdata_reg;

    // once the lock bit is set, source selection is frozen until reset
    assign wr_req_w  = clock_lock_reg ? requested_clock_source_reg
                                      : pwdata_i[OSC_REQ_LSB +: OSC_SRC_W];
    assign wr_swen_w = clock_lock_reg ? clock_switch_enable_reg
                                      : pwdata_i[OSC_SWEN_BIT];

    assign sosc_ready_w = secondary_osc_ready_i & secondary_osc_enable_reg;

    // control word; fields not placed below read zero
    always_comb begin
        ctrl_word_w                                   = '0;
        ctrl_word_w[OSC_RCDIV_LSB +: OSC_SRC_W]       = fast_rc_divider_reg;
        ctrl_word_w[OSC_AUXLP_BIT]                    = aux_lowpower_enable_reg;
        ctrl_word_w[OSC_SRDY_BIT]                     = sosc_ready_w;
        ctrl_word_w[OSC_ACT_LSB +: OSC_SRC_W]         = active_clock_source_reg;
        ctrl_word_w[OSC_REQ_LSB +: OSC_SRC_W]         = requested_clock_source_reg;
        ctrl_word_w[OSC_CLKLOCK_BIT]                  = clock_lock_reg;
        ctrl_word_w[OSC_ULOCK_BIT]                    = usb_pll_lock_i;
        ctrl_word_w[OSC_SLOCK_BIT]                    = sys_pll_lock_i;
        ctrl_word_w[OSC_SLPEN_BIT]                    = sleep_enable_reg;
        ctrl_word_w[OSC_FAIL_BIT]                     = clock_fail_flag_reg;
        ctrl_word_w[OSC_SEC_EN_BIT]                   = secondary_osc_enable_reg;
        ctrl_word_w[OSC_SWEN_BIT]                     = clock_switch_enable_reg;
    end

    // read data is caught in the setup phase so it stands during access
    always_comb begin
        prdata_next = prdata_reg;
        if (setup_w & ~pwrite_i) begin
            if (hit_ctrl_w) begin
                prdata_next = ctrl_word_w;
            end else if (hit_key_w) begin
                prdata_next = {31'h0, unlocked_w};
            end else if (hit_stat_w) begin
                prdata_next = {{(32-OSC_IRQ_W){1'b0}}, irq_stat_reg};
            end else if (hit_mask_w) begin
                prdata_next = {{(32-OSC_IRQ_W){1'b0}}, irq_mask_reg};
            end else begin
                prdata_next = '0;
            end
        end
    end

    // unlock: first key then second key, consumed by one control write
    always_comb begin
        key_state_next = key_state_reg;
        if (key_wr_w) begin
            if (pwdata_i == OSC_KEY_FIRST) begin
                key_state_next = OSC_KEY_HALF;
            end else if ((pwdata_i == OSC_KEY_SECOND) && (key_state_reg == OSC_KEY_HALF)) begin
                key_state_next = OSC_KEY_OPEN;
            end else begin
                key_state_next = OSC_KEY_LOCKED;
            end
        end else if (ctrl_wr_w) begin
            key_state_next = OSC_KEY_LOCKED;
        end
    end

    // failure detection sets the flag; a set beats a software clear
    assign fail_evt_w = clock_fail_i & ~clock_fail_flag_reg;
    assign clock_fail_flag_next = clock_fail_i
                                | (ctrl_wr_w ? pwdata_i[OSC_FAIL_BIT] : clock_fail_flag_reg);

    // clock switch sequencer
    always_comb begin
        sw_state_next            = sw_state_reg;
        active_clock_source_next = active_clock_source_reg;
        clock_switch_enable_next = clock_switch_enable_reg;
        if (ctrl_wr_w) begin
            clock_switch_enable_next = wr_swen_w;
        end
        case (sw_state_reg)
            OSC_SW_IDLE: begin
                if (clock_switch_enable_reg & ~cfg_load_reg) begin
                    if (requested_clock_source_reg == OSC_SRC_RSVD) begin
                        clock_switch_enable_next = 1'b0;
                    end else begin
                        sw_state_next = OSC_SW_WAIT;
                    end
                end
            end
            OSC_SW_WAIT: begin
                if (clock_fail_i) begin
                    clock_switch_enable_next = 1'b0;
                    sw_state_next            = OSC_SW_IDLE;
                end else if (src_ready_i[requested_clock_source_reg]) begin
                    active_clock_source_next = osc_src_t'(requested_clock_source_reg);
                    sw_state_next            = OSC_SW_DONE;
                end
            end
            OSC_SW_DONE: begin
                clock_switch_enable_next = 1'b0;
                sw_state_next            = OSC_SW_IDLE;
            end
            default: begin
                sw_state_next = OSC_SW_IDLE;
            end
        endcase
        // a failure seen while the fail flag is clear falls back to the backup rc at once
        if (fail_evt_w) begin
            active_clock_source_next = OSC_SRC_BACKUP;
        end
    end

    assign switch_evt_w = (sw_state_reg == OSC_SW_DONE);

    // interrupt status: write one to clear, a new event wins
    assign irq_evt_w[OSC_IRQ_SWITCH] = switch_evt_w;
    assign irq_evt_w[OSC_IRQ_FAIL]   = fail_evt_w;
    assign irq_evt_w[OSC_IRQ_SRDY]   = sosc_ready_w & ~srdy_prev_reg;
    assign irq_stat_next = (irq_stat_reg & ~(stat_wr_w ? pwdata_i[OSC_IRQ_W-1:0] : '0))
                         | irq_evt_w;
    assign irq_o         = |(irq_stat_reg & irq_mask_reg);

    // bus-side and sequencer registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_reg              <= '0;
            key_state_reg           <= OSC_KEY_LOCKED;
            sw_state_reg            <= OSC_SW_IDLE;
            active_clock_source_reg <= OSC_SRC_RC_DIV;
            clock_fail_flag_reg     <= 1'b0;
            irq_stat_reg            <= '0;
            irq_mask_reg            <= '0;
            srdy_prev_reg           <= 1'b0;
        end else begin
            prdata_reg              <= prdata_next;
            key_state_reg           <= key_state_next;
            sw_state_reg            <= sw_state_next;
            active_clock_source_reg <= active_clock_source_next;
            clock_fail_flag_reg     <= clock_fail_flag_next;
            irq_stat_reg            <= irq_stat_next;
            srdy_prev_reg           <= sosc_ready_w;
            if (mask_wr_w) begin
                irq_mask_reg <= pwdata_i[OSC_IRQ_W-1:0];
            end
        end
    end

    // plain control fields
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            fast_rc_divider_reg     <= OSC_RCDIV_RST;
            aux_lowpower_enable_reg <= 1'b0;
            clock_lock_reg          <= 1'b0;
            sleep_enable_reg        <= 1'b0;
        end else if (ctrl_wr_w) begin
            fast_rc_divider_reg     <= pwdata_i[OSC_RCDIV_LSB +: OSC_SRC_W];
            aux_lowpower_enable_reg <= pwdata_i[OSC_AUXLP_BIT];
            clock_lock_reg          <= clock_lock_reg | pwdata_i[OSC_CLKLOCK_BIT];
            sleep_enable_reg        <= pwdata_i[OSC_SLPEN_BIT];
        end
    end

    // configuration-loaded fields are caught on the first edge after reset
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_load_reg               <= 1'b1;
            requested_clock_source_reg <= OSC_SRC_RC_DIV;
            secondary_osc_enable_reg   <= 1'b0;
            clock_switch_enable_reg    <= 1'b0;
        end else if (cfg_load_reg) begin
            cfg_load_reg               <= 1'b0;
            requested_clock_source_reg <= cfg_req_source_i;
            secondary_osc_enable_reg   <= cfg_sosc_enable_i;
            clock_switch_enable_reg    <= two_speed_startup_cfg_i;
        end else begin
            clock_switch_enable_reg <= clock_switch_enable_next;
            if (ctrl_wr_w) begin
                requested_clock_source_reg <= wr_req_w;
                secondary_osc_enable_reg   <= pwdata_i[OSC_SEC_EN_BIT];
            end
        end
    end

    osc_rc_div #(
        .DIV_W (OSC_DIV_W)
    ) u_rc_div (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .div_code_i (fast_rc_divider_reg),
        .tick_o     (fast_rc_tick_o)
    );

    assign active_clock_source_o  = active_clock_source_reg;
    assign aux_lowpower_enable_o  = aux_lowpower_enable_reg;
    assign sleep_enable_o         = sleep_enable_reg;
    assign secondary_osc_enable_o = secondary_osc_enable_reg;
    assign switch_busy_o          = clock_switch_enable_reg;

endmodule // osc_ctrl

// *** osc_ctrl_chk.sv ***
`timescale 1ns/1ps
module osc_ctrl_chk (
    // clock and reset
    input wire logic                       clk_sys_i,
    input wire logic                       rst_i,
    // apb
    input wire logic [osc_pkg::OSC_AW-1:0] paddr_i,
    input wire logic                       psel_i,
    input wire logic                       penable_i,
    input wire logic                       pwrite_i,
    input wire logic [31:0]                prdata_o,
    input wire logic                       pslverr_o,
    // configuration and sources
    input wire logic                       cfg_sosc_enable_i,
    input wire logic                       two_speed_startup_cfg_i,
    input wire logic [7:0]                 src_ready_i,
    input wire logic                       secondary_osc_ready_i,
    input wire logic                       clock_fail_i,
    // clock system outputs
    input wire logic [2:0]                 active_clock_source_o,
    input wire logic                       fast_rc_tick_o,
    input wire logic                       aux_lowpower_enable_o,
    input wire logic                       secondary_osc_enable_o,
    input wire logic                       switch_busy_o
);
    import osc_pkg::*;
    wire ctl_acc = psel_i && penable_i && paddr_i == OSC_CTRL_ADDR;
    wire wr_ok   = ctl_acc && pwrite_i && !pslverr_o;
    wire rd_ctl  = ctl_acc && !pwrite_i;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_switch;
        $changed(active_clock_source_o) && !$past(clock_fail_i);
    endsequence
    a_aux_write: assert property (
        $changed(aux_lowpower_enable_o) |-> $past(wr_ok))
        else $error("aux mode changed unwritten");
    a_ctrl_readback: assert property (
        rd_ctl |-> prdata_o[14:12] == $past(active_clock_source_o)
            && prdata_o[23] == $past(aux_lowpower_enable_o)
            && prdata_o[22] == $past(secondary_osc_ready_i && secondary_osc_enable_o))
        else $error("control readback wrong");
    a_ro_zero: assert property (
        rd_ctl |-> (prdata_o & 32'hF83F_8800) == 32'h0000_0000)
        else $error("reserved bits nonzero");
    a_cfg_sosc: assert property (
        $fell(rst_i) |=> secondary_osc_enable_o == $past(cfg_sosc_enable_i))
        else $error("secondary enable not from cfg");
    a_cfg_switch: assert property (
        $fell(rst_i) |=> switch_busy_o == $past(two_speed_startup_cfg_i))
        else $error("switch enable not from cfg");
    a_switch_ready: assert property (
        s_switch |-> |($past(src_ready_i) & (8'h01 << active_clock_source_o)))
        else $error("switched to unready source");
    a_switch_clear: assert property (
        s_switch |-> switch_busy_o ##1 !switch_busy_o)
        else $error("switch enable not cleared");
    a_fail_backup: assert property (
        $past(clock_fail_i) && $changed(active_clock_source_o) |-> active_clock_source_o == OSC_SRC_BACKUP)
        else $error("no fallback to backup rc");
    a_tick_reset: assert property (
        $fell(rst_i) |-> ##[1:3] fast_rc_tick_o [*3])
        else $error("tick not continuous after reset");
    c_switch: cover property (s_switch);
    c_fail: cover property ($rose(clock_fail_i) ##1 active_clock_source_o == OSC_SRC_BACKUP);
    c_refuse: cover property (ctl_acc && pwrite_i && pslverr_o);
endmodule // osc_ctrl_chk

// *** osc_frc_div.sv ***
`timescale 1ns/1ps
module osc_rc_div #(
    parameter int DIV_W = osc_pkg::OSC_DIV_W
) (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    // divider control
    input  wire logic [2:0] div_code_i,
    // one-cycle enable at the divided rate
    output logic            tick_o
);
    import osc_pkg::*;

    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic             tick_reg;
    logic [DIV_W-1:0] last_w;
    logic             wrap_w;

    // a shrinking code wraps at once instead of running to the old end
    assign last_w   = osc_div_last(div_code_i);
    assign wrap_w   = (cnt_reg >= last_w);
    assign cnt_next = wrap_w ? '0 : cnt_reg + 1'b1;
    assign tick_o   = tick_reg;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= wrap_w;
        end
    end

endmodule // osc_rc_div

// *** osc_pkg.sv ***
package osc_pkg;

    // register byte addresses
    localparam int          OSC_AW          = 8;
    localparam logic [7:0]  OSC_CTRL_ADDR   = 8'h00;
    localparam logic [7:0]  OSC_KEY_ADDR    = 8'h04;
    localparam logic [7:0]  OSC_STAT_ADDR   = 8'h08;
    localparam logic [7:0]  OSC_MASK_ADDR   = 8'h0C;

    // control word field positions
    localparam int          OSC_SRC_W       = 3;
    localparam int          OSC_RCDIV_LSB   = 24;
    localparam int          OSC_AUXLP_BIT   = 23;
    localparam int          OSC_SRDY_BIT    = 22;
    localparam int          OSC_ACT_LSB     = 12;
    localparam int          OSC_REQ_LSB     = 8;
    localparam int          OSC_CLKLOCK_BIT = 7;
    localparam int          OSC_ULOCK_BIT   = 6;
    localparam int          OSC_SLOCK_BIT   = 5;
    localparam int          OSC_SLPEN_BIT   = 4;
    localparam int          OSC_FAIL_BIT    = 3;
    localparam int          OSC_SEC_EN_BIT  = 1;
    localparam int          OSC_SWEN_BIT    = 0;
    localparam logic [2:0]  OSC_RCDIV_RST   = 3'h0;

    // unlock keys, values arbitrary
    localparam logic [31:0] OSC_KEY_FIRST   = 32'h0000_C1A5;
    localparam logic [31:0] OSC_KEY_SECOND  = 32'h0000_5A1C;

    // interrupt status bits
    localparam int          OSC_IRQ_W       = 3;
    localparam int          OSC_IRQ_SWITCH  = 0;
    localparam int          OSC_IRQ_FAIL    = 1;
    localparam int          OSC_IRQ_SRDY    = 2;

    localparam int          OSC_DIV_W       = 8;

    typedef enum logic [2:0] {
        OSC_SRC_RC_DIV   = 3'h0,
        OSC_SRC_SYS_PLL  = 3'h1,
        OSC_SRC_PRIMARY  = 3'h2,
        OSC_SRC_RSVD     = 3'h3,
        OSC_SRC_SECOND   = 3'h4,
        OSC_SRC_LP_RC    = 3'h5,
        OSC_SRC_BACKUP   = 3'h6,
        OSC_SRC_RC_DIV7  = 3'h7
    } osc_src_t;

    typedef enum logic [1:0] {
        OSC_SW_IDLE = 2'h0,
        OSC_SW_WAIT = 2'h1,
        OSC_SW_DONE = 2'h2
    } osc_sw_state_t;

    typedef enum logic [1:0] {
        OSC_KEY_LOCKED = 2'h0,
        OSC_KEY_HALF   = 2'h1,
        OSC_KEY_OPEN   = 2'h2
    } osc_key_state_t;

    // last count of the fast rc divider for each divider code
    function automatic logic [OSC_DIV_W-1:0] osc_div_last(input logic [2:0] code);
        case (code)
            3'h0:    osc_div_last = 8'h00;
            3'h1:    osc_div_last = 8'h01;
            3'h2:    osc_div_last = 8'h03;
            3'h3:    osc_div_last = 8'h07;
            3'h4:    osc_div_last = 8'h0F;
            3'h5:    osc_div_last = 8'h1F;
            3'h6:    osc_div_last = 8'h3F;
            default: osc_div_last = 8'hFF;
        endcase
    endfunction

endpackage

// *** osc_src_model.sv ***
`timescale 1ns/1ps
module osc_src_model (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    // bench control and block outputs
    input  wire logic [7:0] src_on_i,
    input  wire logic       sosc_enable_i,
    input  wire logic       fail_i,
    // source status
    output logic      [7:0] src_ready_o,
    output logic            sosc_ready_o,
    output logic            clock_fail_o,
    output logic            pll_lock_o
);
    logic [7:0] on_reg;
    logic [3:0] warm_reg;
    // sources answer two cycles late, the secondary one after a warm-up
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            on_reg      <= 8'h00;
            src_ready_o <= 8'h00;
            warm_reg    <= 4'h0;
        end else begin
            on_reg      <= src_on_i;
            src_ready_o <= on_reg;
            warm_reg    <= !sosc_enable_i ? 4'h0 : warm_reg + {3'h0, warm_reg != 4'hF};
        end
    end
    assign sosc_ready_o = warm_reg == 4'hF;
    assign clock_fail_o = fail_i;
    assign pll_lock_o   = src_ready_o[1];
endmodule // osc_src_model

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin fails++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (x)); end end
module testbench;
    import osc_pkg::*;
    logic        clk_sys_i = 1'h0;
    logic        rst_i     = 1'h1;
    logic [7:0]  paddr_i   = 8'h00;
    logic        psel_i    = 1'h0;
    logic        penable_i = 1'h0;
    logic        pwrite_i  = 1'h0;
    logic [31:0] pwdata_i  = 32'h0;
    logic [2:0]  cfg_req_source_i        = 3'h2;
    logic        cfg_sosc_enable_i       = 1'h1;
    logic        two_speed_startup_cfg_i = 1'h1;
    logic [7:0]  src_on   = 8'hFF;
    logic        fail_req = 1'h0;
    wire  [7:0]  src_ready_i;
    wire         secondary_osc_ready_i;
    wire         sys_pll_lock_i;
    wire         clock_fail_i;
    logic [31:0] prdata_o;
    logic [2:0]  active_clock_source_o;
    logic        pready_o, pslverr_o, fast_rc_tick_o, aux_lowpower_enable_o;
    logic        sleep_enable_o, secondary_osc_enable_o, switch_busy_o, irq_o;
    logic [31:0] q;
    logic        e;
    int          fails = 0;
    int          compares = 0;

    osc_ctrl u_dut (.*, .usb_pll_lock_i(sys_pll_lock_i));
    osc_src_model u_src (.clk_sys_i, .rst_i, .src_on_i(src_on),
        .sosc_enable_i(secondary_osc_enable_o), .fail_i(fail_req), .src_ready_o(src_ready_i),
        .sosc_ready_o(secondary_osc_ready_i), .clock_fail_o(clock_fail_i),
        .pll_lock_o(sys_pll_lock_i));

    always #20 clk_sys_i = ~clk_sys_i;

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel_i   <= 1'h1;
        paddr_i  <= a;
        pwrite_i <= w;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'h1;
        for (int n = 0; n < 20; n++) begin
            @(posedge clk_sys_i);
            if (pready_o === 1'h1) break;
        end
        if (pready_o !== 1'h1) fails++;
        q = prdata_o;
        e = pslverr_o;
        psel_i    <= 1'h0;
        penable_i <= 1'h0;
        @(negedge clk_sys_i);
    endtask

    task automatic rdc;
        apb(OSC_CTRL_ADDR, 1'h0, 32'h0);
    endtask

    task automatic wrc(input logic [2:0] dv, input logic ax, input logic [2:0] rq, input logic sw);
        apb(OSC_CTRL_ADDR, 1'h1, {5'h00, dv, ax, 12'h000, rq, 6'h00, 1'h1, sw});
    endtask

    task automatic unlock;
        apb(OSC_KEY_ADDR, 1'h1, OSC_KEY_FIRST);
        apb(OSC_KEY_ADDR, 1'h1, OSC_KEY_SECOND);
    endtask

    task automatic wait_idle;
        for (int n = 0; n < 400 && switch_busy_o !== 1'h0; n++) @(negedge clk_sys_i);
    endtask

    task automatic do_reset(input logic ts, input logic [2:0] rq);
        @(posedge clk_sys_i);
        rst_i                   <= 1'h1;
        two_speed_startup_cfg_i <= ts;
        cfg_req_source_i        <= rq;
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'h0;
    endtask

    task automatic t_reset;
        rdc;
        `CHK(q[26:24], 3'h0)
        `CHK(q[23], 1'h0)
        `CHK(q[22], 1'h0)
        `CHK(q[10:8], 3'h2)
        `CHK(q[1], 1'h1)
        `CHK(q[0], 1'h1)
        wait_idle;
        `CHK(active_clock_source_o, 3'h2)
        repeat (16) @(negedge clk_sys_i);
        rdc;
        `CHK(q[14:12], 3'h2)
        `CHK(q[22], 1'h1)
        `CHK(q & 32'hF83F_8800, 32'h0)
        do_reset(1'h0, 3'h0);
        rdc;
        `CHK(q[0], 1'h0)
        $display("t_reset done");
    endtask

    task automatic t_unlock;
        wrc(3'h0, 1'h1, 3'h0, 1'h0);
        `CHK(e, 1'h1)
        `CHK(aux_lowpower_enable_o, 1'h0)
        unlock;
        wrc(3'h0, 1'h1, 3'h0, 1'h0);
        `CHK(e, 1'h0)
        `CHK(aux_lowpower_enable_o, 1'h1)
        wrc(3'h0, 1'h0, 3'h0, 1'h0);
        `CHK(e, 1'h1)
        `CHK(aux_lowpower_enable_o, 1'h1)
        unlock;
        apb(OSC_CTRL_ADDR, 1'h1, 32'hF83F_8802);
        `CHK(aux_lowpower_enable_o, 1'h0)
        rdc;
        `CHK(q & 32'hF83F_8800, 32'h0)
        apb(8'h10, 1'h0, 32'h0);
        `CHK(e, 1'h1)
        `CHK(q, 32'h0)
        $display("t_unlock done");
    endtask

    task automatic t_divider;
        int n;
        for (int c = 0; c < 8; c++) begin
            unlock;
            wrc(c[2:0], 1'h0, 3'h0, 1'h0);
            for (n = 0; n < 300 && fast_rc_tick_o !== 1'h1; n++) @(negedge clk_sys_i);
            n = 0;
            do begin
                @(negedge clk_sys_i);
                n++;
            end while (fast_rc_tick_o !== 1'h1 && n < 300);
            `CHK(n, (c == 7) ? 256 : (1 << c))
        end
        $display("t_divider done");
    endtask

    task automatic t_switch;
        logic [2:0] codes [7] = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h3};
        logic [2:0] prev;
        prev   = 3'h0;
        @(posedge clk_sys_i);
        src_on <= 8'hFD;
        for (int i = 0; i < 7; i++) begin
            unlock;
            wrc(3'h0, 1'h0, codes[i], 1'h1);
            if (i == 0) begin
                repeat (10) @(negedge clk_sys_i);
                `CHK(switch_busy_o, 1'h1)
                `CHK(active_clock_source_o, prev)
                @(posedge clk_sys_i);
                src_on <= 8'hFF;
            end
            wait_idle;
            if (codes[i] != 3'h3) begin
                prev = codes[i];
            end
            `CHK(active_clock_source_o, prev)
            rdc;
            `CHK(q[0], 1'h0)
        end
        apb(OSC_STAT_ADDR, 1'h0, 32'h0);
        `CHK(q[OSC_IRQ_SWITCH], 1'h1)
        `CHK(irq_o, 1'h0)
        apb(OSC_MASK_ADDR, 1'h1, 32'h1);
        `CHK(irq_o, 1'h1)
        apb(OSC_STAT_ADDR, 1'h1, 32'h1);
        `CHK(irq_o, 1'h0)
        $display("t_switch done");
    endtask

    task automatic t_fail;
        apb(OSC_MASK_ADDR, 1'h1, 32'h2);
        @(posedge clk_sys_i);
        fail_req <= 1'h1;
        @(posedge clk_sys_i);
        fail_req <= 1'h0;
        @(negedge clk_sys_i);
        `CHK(active_clock_source_o, OSC_SRC_BACKUP)
        `CHK(irq_o, 1'h1)
        rdc;
        `CHK(q[OSC_FAIL_BIT], 1'h1)
        unlock;
        wrc(3'h0, 1'h0, 3'h0, 1'h0);
        rdc;
        `CHK(q[OSC_FAIL_BIT], 1'h0)
        apb(OSC_STAT_ADDR, 1'h1, 32'h2);
        `CHK(irq_o, 1'h0)
        $display("t_fail done");
    endtask

    task automatic wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        do_reset(1'h1, 3'h2);
        t_reset;
        t_unlock;
        t_divider;
        t_switch;
        t_fail;
        wrap_up;
    end

    initial begin
        #800000;
        fails++;
        wrap_up;
    end
endmodule // testbench

bind osc_ctrl osc_ctrl_chk u_chk (.*);
